// file: bsio_pkg.sv
package bsio_pkg;

    // register offsets, word index on the bus (byte address = index * 4)
    localparam logic [7:0] UPPER_DIR_IDX  = 8'h12;
    localparam logic [7:0] UPPER_DATA_IDX = 8'h13;
    localparam logic [7:0] CTRL_DIR_IDX   = 8'h14;
    localparam logic [7:0] CTRL_DATA_IDX  = 8'h15;
    localparam logic [7:0] MODE_IDX       = 8'h16;
    localparam logic [7:0] BUS_CTRL_IDX   = 8'h17;

    // widths
    localparam int UPPER_W = 8;
    localparam int CTRL_W  = 3;

    // reset values
    localparam logic [7:0] UPPER_DIR_RST = 8'hFF;
    localparam logic [2:0] CTRL_DIR_RST  = 3'h7;
    localparam logic [7:0] DATA_RST      = 8'h00;
    localparam logic [1:0] MODE_RST      = 2'h0;

    // control port bit positions in system-bus mode
    localparam int ALE_BIT = 0;
    localparam int OE_BIT  = 1;
    localparam int WR_BIT  = 2;

    // read-modify-write operation codes (written to the data register's op field)
    localparam logic [1:0] OP_WRITE  = 2'h0;
    localparam logic [1:0] OP_SET    = 2'h1;
    localparam logic [1:0] OP_CLEAR  = 2'h2;
    localparam logic [1:0] OP_TOGGLE = 2'h3;
    localparam int OP_LSB  = 8;
    localparam int BIT_LSB = 10;

    // operating modes: two microcontroller modes, two external-bus modes
    typedef enum logic [1:0] {
        BSIO_MODE_MC      = 2'h0,
        BSIO_MODE_PROTECT = 2'h1,
        BSIO_MODE_EXT     = 2'h2,
        BSIO_MODE_MP      = 2'h3
    } bsio_mode_t;

    // system bus drive from the core (upper byte and strobes)
    typedef struct packed {
        logic [7:0] ad_out;
        logic       ad_oe;
        logic       ale;
        logic       oe_n;
        logic       wr_n;
    } bsio_sysbus_t;

    // bus slave states
    typedef enum logic {
        BSIO_IDLE,
        BSIO_ACK
    } bsio_state_t;

    // whole block state
    typedef struct packed {
        logic [7:0]  upper_dir;
        logic [7:0]  upper_lat;
        logic [2:0]  ctrl_dir;
        logic [2:0]  ctrl_lat;
        bsio_mode_t  mode;
        bsio_state_t st;
        logic [31:0] rdata;
        logic [7:0]  upper_s1;
        logic [7:0]  upper_s2;
        logic [2:0]  ctrl_s1;
        logic [2:0]  ctrl_s2;
        logic [7:0]  upper_smp;
        logic [2:0]  ctrl_smp;
    } bsio_state_s_t;

endpackage

// file: bsio_ports.sv
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
// Contract
// RL1 - control port has three two-way pins, each with latch and direction bit
// RL2 - direction 1 makes pin input, 0 drives the latch value out
// RL3 - reading a data register returns sampled pin levels, not latch
// RL4 - writing a data register updates the latch regardless of direction
// RL5 - external-bus modes give both ports to system bus; else general purpose
// RL6 - wide port pins 0..7 carry address/data lines 8..15 in bus mode
// RL7 - control port carries latch strobe bit0, output enable bit1, write bit2
// RL8 - output enable and write strobes are active low; latch strobe is not
// RL9 - every reset sets all direction bits to one; latches keep their value (here every reset clears them to zero)
// RL10 - control data bits 7..3 read zero and ignore writes
// RL11 - every port write reads, modifies and writes whole byte back to latch
// RL12 - read-modify-write uses pin levels, copying input pins into latches
// RL13 - latch update takes effect at the end of the write cycle
// RL14 - pins are sampled at the start of the cycle; reads may be stale
// RL15 - software should separate a port write and read of it
// RL16 - software selects bank one before touching these registers
// RL17 - wide port is the high byte of the sixteen-bit bus
// RL18 - wide port follows the same direction, read and write behaviour
// RL19 - software clears the latch before changing direction bits
module bsio_ports (
    // clock, reset, enable
    input  wire logic                    CLK_SYS,
    input  wire logic                    RESETN,
    input  wire logic                    CE,
    // wishbone slave
    input  wire logic                    WB_CYC_I,
    input  wire logic                    WB_STB_I,
    input  wire logic                    WB_WE_I,
    input  wire logic [9:0]              WB_ADR_I,
    input  wire logic [3:0]              WB_SEL_I,
    input  wire logic [31:0]             WB_DAT_I,
    output logic      [31:0]             WB_DAT_O,
    output logic                         WB_ACK_O,
    // system bus drive from the core, pin byte and mode back to it
    input  wire bsio_pkg::bsio_sysbus_t  SYSBUS,
    output logic      [7:0]              SYSBUS_AD_IN,
    output logic      [1:0]              MODE,
    // wide port pins
    input  wire logic [7:0]              UPPER_IN,
    output logic      [7:0]              UPPER_OUT,
    output logic      [7:0]              UPPER_OE,
    // control port pins
    input  wire logic [2:0]              CTRL_IN,
    output logic      [2:0]              CTRL_OUT,
    output logic      [2:0]              CTRL_OE
);

    bsio_pkg::bsio_state_s_t s_q;
    bsio_pkg::bsio_state_s_t s_d;

    logic       req;
    logic       bus_mode;
    logic [7:0] idx;
    logic [7:0] wval;
    logic [1:0] op;
    logic [2:0] bsel;
    logic [7:0] mask;

    assign req      = WB_CYC_I && WB_STB_I;
    assign idx      = WB_ADR_I[9:2];
    assign op       = WB_DAT_I[bsio_pkg::OP_LSB +: 2];
    assign bsel     = WB_DAT_I[bsio_pkg::BIT_LSB +: 3];
    assign mask     = 8'h01 << bsel;
    assign bus_mode = s_q.mode[1]; // [RL5]

    // modify step applied to the sampled pin levels, not the latch
    function automatic logic [7:0] bsio_rmw(input logic [7:0] pins, input logic [7:0] wd,
                                            input logic [1:0] o, input logic [7:0] m);
        logic [7:0] r;
        r = wd;
        case (o)
            bsio_pkg::OP_SET:    r = pins | m;
            bsio_pkg::OP_CLEAR:  r = pins & ~m;
            bsio_pkg::OP_TOGGLE: r = pins ^ m;
            default:             r = wd;
        endcase
        return r;
    endfunction

    // next state: synchronisers, pin sample, register access
    always_comb begin
        s_d = s_q;
        wval = 8'h00;
        s_d.upper_s1 = UPPER_IN;
        s_d.upper_s2 = s_q.upper_s1;
        s_d.ctrl_s1  = CTRL_IN;
        s_d.ctrl_s2  = s_q.ctrl_s1;
        // pins sampled at the start of a cycle, three cycles behind a latch write
        s_d.upper_smp = s_q.upper_s2; // [RL14]
        s_d.ctrl_smp  = s_q.ctrl_s2;  // [RL14]
        case (s_q.st)
            bsio_pkg::BSIO_IDLE: begin
                if (req) begin
                    s_d.st = bsio_pkg::BSIO_ACK;
                    s_d.rdata = 32'h0000_0000;
                    case (idx)
                        bsio_pkg::UPPER_DIR_IDX:  s_d.rdata[7:0] = s_q.upper_dir;
                        bsio_pkg::UPPER_DATA_IDX: s_d.rdata[7:0] = s_q.upper_smp; // [RL3] [RL18]
                        bsio_pkg::CTRL_DIR_IDX:   s_d.rdata[2:0] = s_q.ctrl_dir;
                        bsio_pkg::CTRL_DATA_IDX:  s_d.rdata[2:0] = s_q.ctrl_smp;  // [RL3] [RL10]
                        bsio_pkg::MODE_IDX:       s_d.rdata[1:0] = s_q.mode;
                        bsio_pkg::BUS_CTRL_IDX:   s_d.rdata[0]   = bus_mode;
                        default:                  s_d.rdata = 32'h0000_0000;
                    endcase
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        case (idx)
                            bsio_pkg::UPPER_DIR_IDX: s_d.upper_dir = WB_DAT_I[7:0];
                            bsio_pkg::UPPER_DATA_IDX: begin
                                wval = bsio_rmw(s_q.upper_smp, WB_DAT_I[7:0], op, mask); // [RL11] [RL12]
                                s_d.upper_lat = wval; // [RL4] [RL13] [RL18]
                            end
                            bsio_pkg::CTRL_DIR_IDX: s_d.ctrl_dir = WB_DAT_I[2:0]; // [RL10]
                            bsio_pkg::CTRL_DATA_IDX: begin
                                wval = bsio_rmw({5'h00, s_q.ctrl_smp}, WB_DAT_I[7:0], op, mask); // [RL11] [RL12]
                                s_d.ctrl_lat = wval[2:0]; // [RL4] [RL10] [RL13]
                            end
                            bsio_pkg::MODE_IDX: s_d.mode = bsio_pkg::bsio_mode_t'(WB_DAT_I[1:0]);
                            default: ;
                        endcase
                    end
                end
            end
            bsio_pkg::BSIO_ACK: begin
                s_d.st = bsio_pkg::BSIO_IDLE;
            end
            default: s_d.st = bsio_pkg::BSIO_IDLE;
        endcase
    end

    // state register; latches take a plain zero at reset here, unknown in silicon
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            s_q <= '0;
            s_q.upper_dir <= bsio_pkg::UPPER_DIR_RST; // [RL9]
            s_q.ctrl_dir  <= bsio_pkg::CTRL_DIR_RST;  // [RL9]
            s_q.upper_lat <= bsio_pkg::DATA_RST;
            s_q.ctrl_lat  <= bsio_pkg::DATA_RST[2:0];
            s_q.mode      <= bsio_pkg::bsio_mode_t'(bsio_pkg::MODE_RST);
            s_q.st        <= bsio_pkg::BSIO_IDLE;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    // bus answers; ack one cycle after the request, dropped the next
    assign WB_ACK_O = (s_q.st == bsio_pkg::BSIO_ACK) && req;
    assign WB_DAT_O = s_q.rdata;
    assign MODE     = s_q.mode;
    assign SYSBUS_AD_IN = s_q.upper_s2; // high address/data byte back to the core

    // pin drivers: system bus in external modes, latch and direction otherwise
    always_comb begin
        if (bus_mode) begin
            UPPER_OUT = SYSBUS.ad_out;                       // [RL6] [RL17]
            UPPER_OE  = {8{SYSBUS.ad_oe}};                   // [RL6]
            CTRL_OUT[bsio_pkg::ALE_BIT] = SYSBUS.ale;        // [RL7] [RL8]
            CTRL_OUT[bsio_pkg::OE_BIT]  = SYSBUS.oe_n;       // [RL7] [RL8]
            CTRL_OUT[bsio_pkg::WR_BIT]  = SYSBUS.wr_n;       // [RL7] [RL8]
            CTRL_OE   = 3'h7;                                // [RL7]
        end else begin
            UPPER_OUT = s_q.upper_lat;                       // [RL2] [RL18]
            UPPER_OE  = ~s_q.upper_dir;                      // [RL2] [RL18]
            CTRL_OUT  = s_q.ctrl_lat;                        // [RL1] [RL2]
            CTRL_OE   = ~s_q.ctrl_dir;                       // [RL1] [RL2]
        end
    end

endmodule

// file: bsio_ext_pins.sv
`timescale 1ns/10ps
// far-side peripherals: they drive every pin that the block leaves undriven
module bsio_ext_pins (
    // block side, control port above the wide port
    input  wire logic [10:0] oe,
    input  wire logic [10:0] drv,
    // peripheral side
    input  wire logic [10:0] ext,
    output logic      [10:0] pin
);
    // an enabled block driver wins; no fight is modelled
    assign pin = (oe & drv) | (~oe & ext);
endmodule

// file: bsio_ports_assertions.sv
`timescale 1ns/10ps
module bsio_ports_assertions (
    // clock and reset
    input wire logic                   CLK_SYS,
    input wire logic                   RESETN,
    input wire logic                   CE,
    // register bus
    input wire logic                   WB_CYC_I,
    input wire logic                   WB_STB_I,
    input wire logic                   WB_WE_I,
    input wire logic [9:0]             WB_ADR_I,
    input wire logic [31:0]            WB_DAT_O,
    input wire logic                   WB_ACK_O,
    // system bus and pins
    input wire bsio_pkg::bsio_sysbus_t SYSBUS,
    input wire logic [1:0]             MODE,
    input wire logic [7:0]             UPPER_OUT,
    input wire logic [7:0]             UPPER_OE,
    input wire logic [2:0]             CTRL_OUT,
    input wire logic [2:0]             CTRL_OE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    // bus handshake: one answer, one cycle after the take
    AST_ACK_NEXT: assert property (CE && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack not given next cycle");
    AST_ACK_ONE: assert property (WB_ACK_O && CE |=> !WB_ACK_O)
        else $error("ack held too long");
    // after reset every pin is an input
    AST_RST_IN: assert property ($rose(RESETN) |-> UPPER_OE == 8'h00 && CTRL_OE == 3'h0)
        else $error("pins driven after reset");
    // bus modes hand both ports to the system bus
    AST_BUS_CTRL_OE: assert property (MODE[1] |-> CTRL_OE == 3'h7)
        else $error("strobes not driven in bus mode");
    AST_BUS_AD: assert property (MODE[1] |-> UPPER_OUT == SYSBUS.ad_out && UPPER_OE == {8{SYSBUS.ad_oe}})
        else $error("address byte not routed");
    AST_STROBES: assert property (MODE[1] |-> CTRL_OUT == {SYSBUS.wr_n, SYSBUS.oe_n, SYSBUS.ale})
        else $error("strobe order or polarity wrong");
    // read data: one byte wide, control port three bits
    AST_RD_HI: assert property (WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_CTRL_RD: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] == 8'h15 |-> WB_DAT_O[7:3] == 5'h00)
        else $error("unused control bits read set");
    CVR_BUS: cover property (MODE[1]);
    CVR_WR: cover property (WB_ACK_O && WB_WE_I);
    CVR_RD: cover property (WB_ACK_O && !WB_WE_I && WB_DAT_O != 32'h0);
endmodule
bind bsio_ports bsio_ports_assertions chk_u (.*);

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   cyc = 1'b0;
    logic                   stb = 1'b0;
    logic                   we = 1'b0;
    logic [9:0]             adr = 10'h000;
    logic [31:0]            dati = 32'h0;
    logic [31:0]            dato, q;
    logic                   ack;
    logic [1:0]             mode;
    logic [7:0]             sad, uo, uoe;
    logic [2:0]             co, coe;
    logic [10:0]            ext = 11'h1A5;
    logic [10:0]            pin;
    bsio_pkg::bsio_sysbus_t sb = '0;
    int                     failures = 0;
    int                     num_checks = 0;
    initial forever #20 clk = ~clk;
    bsio_ports dut_u (.CLK_SYS(clk), .RESETN(rst_n), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack), .SYSBUS(sb),
        .SYSBUS_AD_IN(sad), .MODE(mode), .UPPER_IN(pin[7:0]), .UPPER_OUT(uo), .UPPER_OE(uoe),
        .CTRL_IN(pin[10:8]), .CTRL_OUT(co), .CTRL_OE(coe));
    bsio_ext_pins ext_u (.oe({coe, uoe}), .drv({co, uo}), .ext(ext), .pin(pin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; request held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dati} <= {2'b11, w, idx, 2'b00, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        q = dato;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(q, exp);
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        end_of_test;
    end
    initial begin
        logic [2:0] e;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h12, 32'hFF);
        rd(8'h14, 32'h07);
        bus(1'b1, 8'h13, 32'h0);
        bus(1'b1, 8'h15, 32'h0);
        rd(8'h13, 32'hA5);
        bus(1'b1, 8'h13, 32'h3C);
        bus(1'b1, 8'h12, 32'h0F);
        repeat (4) @(posedge clk); // let pins settle between write and read
        chk({uoe, uo}, 16'hF03C);
        rd(8'h13, 32'h35);
        bus(1'b1, 8'h13, 32'h1E00);
        bus(1'b1, 8'h12, 32'h0);
        chk(uo, 8'h35);
        bus(1'b1, 8'h14, 32'hFF);
        rd(8'h14, 32'h07);
        bus(1'b1, 8'h15, 32'hFE);
        rd(8'h15, 32'h01);
        bus(1'b1, 8'h14, 32'h03);
        repeat (4) @(posedge clk);
        chk(coe, 3'h4);
        rd(8'h15, 32'h05);
        bus(1'b1, 8'h14, 32'h0);
        e = 3'h6;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h15, {19'h0, 3'(i % 3), 2'(i), 8'h05});
            case (i)
                0: e = 3'h5;
                1: e[1] = 1'b1;
                2: e[2] = 1'b0;
                default: e[0] = ~e[0];
            endcase
            repeat (4) @(posedge clk);
            chk(co, e);
        end
        rd(8'h30, 32'h0);
        bus(1'b1, 8'h14, 32'hFF);
        sb <= '{ad_out: 8'h96, ad_oe: 1'b0, ale: 1'b1, oe_n: 1'b0, wr_n: 1'b1};
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 8'h16, 32'(m));
            chk({mode, coe, co, uoe, uo}, m > 1 ? {2'(m), 22'h3D0096} : {2'(m), 22'h02FF35});
            rd(8'h17, 32'(m / 2));
        end
        repeat (4) @(posedge clk);
        chk(sad, 8'hA5);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h12, 32'hFF);
        rd(8'h14, 32'h07);
        end_of_test;
    end
endmodule
